// >>> design/usbges_pkg.sv
// Constants shared by the general event status block
package usbges_pkg;

  // ==========================================================
  // Bus and data widths
  localparam int USBGES_ADDR_W = 8;
  localparam int USBGES_DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h0a;
  localparam logic [7:0] OFF_EVENT_ENABLE = 8'h0b;
  localparam logic [7:0] OFF_EVENT_CLEAR = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h0d;
  localparam logic [7:0] OFF_RESUME_RAW_STATUS = 8'h0e;
  localparam logic [7:0] OFF_RESUME_IRQ_MASK = 8'h0f;
  localparam logic [7:0] OFF_RESUME_IRQ_CLEAR = 8'h10;

  // ==========================================================
  // Status bit positions; bit 2 means babble in host role, bus reset in device role
  localparam int BIT_SUSPEND = 0;
  localparam int BIT_RESUME = 1;
  localparam int BIT_BABBLE = 2;
  localparam int BIT_BUS_RESET = 2;
  localparam int BIT_SOF = 3;
  localparam int BIT_CONNECT = 4;
  localparam int BIT_DISCONNECT = 5;
  localparam int CTRL_HOST_BIT = 0;
  localparam int RAW_RESUME_BIT = 0;

  // ==========================================================
  // Reset values and bit masks
  localparam logic [7:0] EVENT_STATUS_RST = 8'h00;
  localparam logic [7:0] EVENT_ENABLE_RST = 8'h06;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ENABLE_WR_MASK = 8'h3f;
  localparam logic [7:0] HOST_VALID_MASK = 8'h3e;
  localparam logic [7:0] DEVICE_VALID_MASK = 8'h0f;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZEROS = 8'h00;

endpackage : usbges_pkg

// >>> design/usbges_top.sv
// General event status register with clear-on-read, enable and interrupt
//
// How it works
// RULE_01 - Status is an 8-bit software read-only register, zero after reset.
// RULE_02 - Reading status returns the active events, then clears all of them.
// RULE_03 - Host role: peer disconnect sets bit 5.
// RULE_04 - Host role: peer connect sets bit 4.
// RULE_05 - Either role: each new frame sets bit 3.
// RULE_06 - Host role: babble sets bit 2, only after the first frame start was sent.
// RULE_07 - Either role: resume while suspended sets bit 1.
// RULE_08 - Resume bit only with clock enabled; gated clock uses raw resume registers.
// RULE_09 - Device role: bus reset sets bit 2.
// RULE_10 - Device role: suspend sets bit 0.
// RULE_11 - Unused bits of the active role read zero; software preserves them.
// RULE_12 - Interrupt only for set status bits whose enable is set, or raw resume with its mask bit set; status sets anyway.
// RULE_13 - An event in the same cycle as a clearing read stays set.
`timescale 1ns/100ps
`default_nettype none

module usbges_top
  import usbges_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [USBGES_ADDR_W-1:0] reg_addr_in,
  input wire logic [USBGES_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [USBGES_DATA_W-1:0] reg_rdata_out,
  // Bus event strobes from the link logic
  input wire logic ev_connect_in,
  input wire logic ev_disconnect_in,
  input wire logic ev_sof_in,
  input wire logic ev_babble_in,
  input wire logic ev_resume_in,
  input wire logic ev_bus_reset_in,
  input wire logic ev_suspend_in,
  // Controller state
  input wire logic ctrl_suspended_in,
  input wire logic sys_clk_enabled_in,
  // Interrupt
  output logic irq_out
);

  // ==========================================================
  // Decode
  function automatic logic reg_hit(input logic [USBGES_ADDR_W-1:0] addr,
                                   input logic [USBGES_ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] enable_ff;
  logic [7:0] nxt_enable;
  logic [7:0] control_ff;
  logic [7:0] nxt_control;
  logic raw_resume_ff;
  logic nxt_raw_resume;
  logic raw_mask_ff;
  logic nxt_raw_mask;
  logic sof_sent_ff;
  logic nxt_sof_sent;
  logic irq_ff;
  logic nxt_irq;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  wire status_rd = reg_rd_in & reg_hit(reg_addr_in, OFF_EVENT_STATUS);
  wire enable_wr = reg_wr_in & reg_hit(reg_addr_in, OFF_EVENT_ENABLE);
  wire clear_wr = reg_wr_in & reg_hit(reg_addr_in, OFF_EVENT_CLEAR);
  wire control_wr = reg_wr_in & reg_hit(reg_addr_in, OFF_CONTROL);
  wire raw_mask_wr = reg_wr_in & reg_hit(reg_addr_in, OFF_RESUME_IRQ_MASK);
  wire raw_clear_wr = reg_wr_in & reg_hit(reg_addr_in, OFF_RESUME_IRQ_CLEAR);

  // ==========================================================
  // Role and event qualification
  wire host_role = control_ff[CTRL_HOST_BIT];
  wire [7:0] valid_mask = host_role ? HOST_VALID_MASK : DEVICE_VALID_MASK;
  // A role switch changes the meaning of the bits, so stale events are dropped
  wire role_change = control_wr & (reg_wdata_in[CTRL_HOST_BIT] != host_role);
  wire resume_live = ev_resume_in & ctrl_suspended_in;
  wire resume_clocked = resume_live & sys_clk_enabled_in; // RULE_07 RULE_08
  wire resume_gated = resume_live & ~sys_clk_enabled_in; // RULE_08
  wire babble_ok = host_role & ev_babble_in & sof_sent_ff; // RULE_06
  wire bus_reset_ok = ~host_role & ev_bus_reset_in; // RULE_09

  wire [7:0] events;
  assign events[7:6] = 2'h0; // RULE_11
  assign events[BIT_DISCONNECT] = host_role & ev_disconnect_in; // RULE_03
  assign events[BIT_CONNECT] = host_role & ev_connect_in; // RULE_04
  assign events[BIT_SOF] = ev_sof_in; // RULE_05
  assign events[BIT_BABBLE] = babble_ok | bus_reset_ok; // RULE_06 RULE_09
  assign events[BIT_RESUME] = resume_clocked; // RULE_07
  assign events[BIT_SUSPEND] = ~host_role & ev_suspend_in; // RULE_10 RULE_11

  wire [7:0] clear_vec = (status_rd ? ALL_ONES : ALL_ZEROS) // RULE_02
                       | (clear_wr ? reg_wdata_in : ALL_ZEROS)
                       | (role_change ? ALL_ONES : ALL_ZEROS);

  // ==========================================================
  // Sticky status bits; a set always beats a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < USBGES_DATA_W; gi++)
    begin : g_status
      assign nxt_status[gi] = events[gi] | (status_ff[gi] & ~clear_vec[gi]); // RULE_13
    end
  endgenerate

  // First frame start in host role arms babble reporting
  assign nxt_sof_sent = role_change ? 1'b0
                      : (host_role & ev_sof_in) | sof_sent_ff; // RULE_06

  assign nxt_enable = enable_wr ? (reg_wdata_in & ENABLE_WR_MASK) : enable_ff;
  assign nxt_control = control_wr ? (reg_wdata_in & ALL_ONES) : control_ff;

  // Raw resume path stays live while the controller clock is gated off
  assign nxt_raw_resume = resume_gated
                        | (raw_resume_ff & ~(raw_clear_wr & reg_wdata_in[RAW_RESUME_BIT])); // RULE_08
  assign nxt_raw_mask = raw_mask_wr ? reg_wdata_in[RAW_RESUME_BIT] : raw_mask_ff;

  // Interrupt follows the next state so it rises with the status bit
  assign nxt_irq = (|(nxt_status & nxt_enable)) | (nxt_raw_resume & nxt_raw_mask); // RULE_12

  // ==========================================================
  // Read data: present only in the cycle after the strobe
  logic [7:0] rd_sel;
  assign rd_sel = reg_hit(reg_addr_in, OFF_EVENT_STATUS) ? (status_ff & valid_mask) // RULE_02 RULE_11
                : reg_hit(reg_addr_in, OFF_EVENT_ENABLE) ? enable_ff
                : reg_hit(reg_addr_in, OFF_CONTROL) ? control_ff
                : reg_hit(reg_addr_in, OFF_RESUME_RAW_STATUS) ? {7'h00, raw_resume_ff}
                : reg_hit(reg_addr_in, OFF_RESUME_IRQ_MASK) ? {7'h00, raw_mask_ff}
                : ALL_ZEROS;
  assign nxt_rdata = reg_rd_in ? rd_sel : ALL_ZEROS;

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      status_ff <= EVENT_STATUS_RST; // RULE_01
      enable_ff <= EVENT_ENABLE_RST;
      control_ff <= CONTROL_RST;
      sof_sent_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
      control_ff <= nxt_control;
      sof_sent_ff <= nxt_sof_sent;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      raw_resume_ff <= 1'b0;
      raw_mask_ff <= 1'b0;
      irq_ff <= 1'b0;
      rdata_ff <= ALL_ZEROS;
    end
    else
    begin
      raw_resume_ff <= nxt_raw_resume;
      raw_mask_ff <= nxt_raw_mask;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign irq_out = irq_ff;

  // ==========================================================
  // Assertions
  sequence s_status_read;
    status_rd;
  endsequence

  sequence s_quiet;
    events == ALL_ZEROS;
  endsequence

  property p_read_returns;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_status_read |=> (reg_rdata_out == ($past(status_ff) & $past(valid_mask)));
  endproperty

  property p_read_clears;
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_status_read and s_quiet) |=> (status_ff == ALL_ZEROS);
  endproperty

  AST_STATUS_READ_DATA : assert property (p_read_returns) // RULE_02
    else $error("status read returned wrong data");

  AST_STATUS_READ_CLEAR : assert property (p_read_clears) // RULE_02
    else $error("status read did not clear events");

  AST_DISCONNECT_SET : assert property ( // RULE_03
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_role && ev_disconnect_in && !role_change) |=> status_ff[BIT_DISCONNECT])
    else $error("disconnect event not latched");

  AST_CONNECT_SET : assert property ( // RULE_04
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_role && ev_connect_in && !role_change) |=> status_ff[BIT_CONNECT])
    else $error("connect event not latched");

  AST_SOF_SET : assert property ( // RULE_05
    @(posedge clk_in) disable iff (!rst_n_in)
      ev_sof_in |=> status_ff[BIT_SOF])
    else $error("frame start not latched");

  AST_BABBLE_BLOCKED : assert property ( // RULE_06
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_role && !sof_sent_ff && !status_ff[BIT_BABBLE]) |=> !status_ff[BIT_BABBLE])
    else $error("babble reported before first frame start");

  AST_BABBLE_SET : assert property ( // RULE_06
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_role && sof_sent_ff && ev_babble_in && !role_change) |=> status_ff[BIT_BABBLE])
    else $error("babble not latched");

  AST_RESUME_CLOCKED : assert property ( // RULE_07
    @(posedge clk_in) disable iff (!rst_n_in)
      (ev_resume_in && ctrl_suspended_in && sys_clk_enabled_in) |=> status_ff[BIT_RESUME])
    else $error("resume not latched while suspended");

  AST_RESUME_GATED : assert property ( // RULE_08
    @(posedge clk_in) disable iff (!rst_n_in)
      (ev_resume_in && ctrl_suspended_in && !sys_clk_enabled_in && !status_ff[BIT_RESUME])
        |=> (raw_resume_ff && !status_ff[BIT_RESUME]))
    else $error("gated resume took the wrong path");

  AST_BUS_RESET_SET : assert property ( // RULE_09
    @(posedge clk_in) disable iff (!rst_n_in)
      (!host_role && ev_bus_reset_in && !role_change) |=> status_ff[BIT_BUS_RESET])
    else $error("bus reset not latched");

  AST_SUSPEND_SET : assert property ( // RULE_10
    @(posedge clk_in) disable iff (!rst_n_in)
      (!host_role && ev_suspend_in && !role_change) |=> status_ff[BIT_SUSPEND])
    else $error("suspend not latched");

  AST_UNUSED_ZERO : assert property ( // RULE_11
    @(posedge clk_in) disable iff (!rst_n_in)
      s_status_read |=> ((reg_rdata_out & ~$past(valid_mask)) == ALL_ZEROS))
    else $error("unused status bit read as one");

  AST_IRQ_GATING : assert property ( // RULE_12
    @(posedge clk_in) disable iff (!rst_n_in)
      irq_out == ((|(status_ff & enable_ff)) || (raw_resume_ff && raw_mask_ff)))
    else $error("interrupt disagrees with status and enable");

  AST_EVENT_SURVIVES_READ : assert property ( // RULE_13
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_status_read ##0 ev_sof_in) |=> (status_ff[BIT_SOF] ##1 (status_ff[BIT_SOF] || $past(clear_vec[BIT_SOF]))))
    else $error("event lost on clearing read");

  // ==========================================================
  // Role, reset and raw path guards
  // Bits that the active role cannot produce must never rise on their own
  sequence s_device_role;
    !host_role;
  endsequence

  sequence s_host_role;
    host_role;
  endsequence

  sequence s_reset_held;
    !rst_n_in;
  endsequence

  sequence s_bus_idle;
    !reg_rd_in;
  endsequence

  // No disable here, so the held reset itself is what gets checked
  AST_RESET_VALUES : assert property ( // RULE_01
    @(posedge clk_in)
      s_reset_held |=> (status_ff == EVENT_STATUS_RST && !irq_out && reg_rdata_out == ALL_ZEROS))
    else $error("state not cleared by reset");

  AST_READ_DATA_ONE_CYCLE : assert property ( // RULE_02
    @(posedge clk_in) disable iff (!rst_n_in)
      s_bus_idle |=> (reg_rdata_out == ALL_ZEROS))
    else $error("read data stood past its cycle");

  AST_DISCONNECT_HOST_ONLY : assert property ( // RULE_03
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_device_role ##0 !status_ff[BIT_DISCONNECT]) |=> !status_ff[BIT_DISCONNECT])
    else $error("disconnect latched in device role");

  AST_CONNECT_HOST_ONLY : assert property ( // RULE_04
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_device_role ##0 !status_ff[BIT_CONNECT]) |=> !status_ff[BIT_CONNECT])
    else $error("connect latched in device role");

  AST_SOF_ARMS_BABBLE : assert property ( // RULE_06
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_host_role ##0 (ev_sof_in && !role_change)) |=> sof_sent_ff)
    else $error("frame start did not arm babble");

  AST_RESUME_NEEDS_SUSPEND : assert property ( // RULE_07
    @(posedge clk_in) disable iff (!rst_n_in)
      (!ctrl_suspended_in && !status_ff[BIT_RESUME]) |=> !status_ff[BIT_RESUME])
    else $error("resume latched while not suspended");

  AST_RAW_NEEDS_GATE : assert property ( // RULE_08
    @(posedge clk_in) disable iff (!rst_n_in)
      (sys_clk_enabled_in && !raw_resume_ff) |=> !raw_resume_ff)
    else $error("raw resume set with clock enabled");

  AST_RAW_CLEAR : assert property ( // RULE_08
    @(posedge clk_in) disable iff (!rst_n_in)
      (raw_clear_wr && reg_wdata_in[RAW_RESUME_BIT] && !resume_gated) |=> !raw_resume_ff)
    else $error("raw resume not cleared");

  AST_SUSPEND_DEVICE_ONLY : assert property ( // RULE_10
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_host_role ##0 !status_ff[BIT_SUSPEND]) |=> !status_ff[BIT_SUSPEND])
    else $error("suspend latched in host role");

  AST_UPPER_BITS_ZERO : assert property ( // RULE_11
    @(posedge clk_in) disable iff (!rst_n_in)
      (status_ff & ~(HOST_VALID_MASK | DEVICE_VALID_MASK)) == ALL_ZEROS)
    else $error("unused status bit set");

  AST_ENABLE_WRITE : assert property ( // RULE_12
    @(posedge clk_in) disable iff (!rst_n_in)
      enable_wr |=> (enable_ff == $past(reg_wdata_in & ENABLE_WR_MASK)))
    else $error("enable write not taken");

  AST_CONNECT_SURVIVES_READ : assert property ( // RULE_13
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_status_read ##0 (host_role && ev_connect_in)) |=> status_ff[BIT_CONNECT])
    else $error("connect lost on clearing read");

endmodule : usbges_top

`default_nettype wire

// >>> tb/usbges_peer.sv
// Bus peer model that raises one event strobe per request
`timescale 1ns/100ps
`default_nettype none

module usbges_peer
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request from the bench
  input wire logic req_in,
  input wire logic [2:0] sel_in,
  // Event strobes
  output logic [6:0] ev_out
);
  // ==========
  // Strobe
  // Follows req_in one cycle late, so a one-cycle request is exactly one event
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ev_out <= 7'h00;
    else
      ev_out <= req_in ? (7'h01 << sel_in) : 7'h00;
  end
endmodule : usbges_peer
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the general event status block
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import usbges_pkg::*;
();
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic req = 1'b0;
  logic [2:0] sel = 3'h0;
  logic susp = 1'b0;
  logic clken = 1'b1;
  logic [7:0] rdata;
  logic irq;
  logic [6:0] ev;
  int n_fail = 0;
  int compares = 0;
  int st = 0, en = 6, host = 0, sofd = 0, raw = 0, msk = 0, seed, k;

  always #2 clk_in = ~clk_in;

  usbges_peer peer (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .sel_in(sel), .ev_out(ev));

  usbges_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ev_connect_in(ev[0]),
    .ev_disconnect_in(ev[1]), .ev_sof_in(ev[2]), .ev_babble_in(ev[3]), .ev_resume_in(ev[4]),
    .ev_bus_reset_in(ev[5]), .ev_suspend_in(ev[6]), .ctrl_suspended_in(susp),
    .sys_clk_enabled_in(clken), .irq_out(irq));

  // ==========
  // Checks and model
  task automatic cmp_data(input logic [7:0] exp);
    compares++;
    if (rdata !== exp)
      $display("BAD %0t read %h want %h", $time, rdata, exp);
    if (rdata !== exp)
      n_fail++;
  endtask : cmp_data

  task automatic cmp_irq();
    logic exp;
    exp = ((st & en) != 0) || ((raw & msk) != 0);
    compares++;
    if (irq !== exp)
      $display("BAD %0t irq %b want %b", $time, irq, exp);
    if (irq !== exp)
      n_fail++;
  endtask : cmp_irq

  task automatic apply(input int i);
    if (i == 0 && host != 0) st |= 8'h10;
    if (i == 1 && host != 0) st |= 8'h20;
    if (i == 3 && host != 0 && sofd != 0) st |= 8'h04;
    if (i == 2 && host != 0) sofd = 1;
    if (i == 2) st |= 8'h08;
    if (i == 4 && susp && clken) st |= 8'h02;
    if (i == 4 && susp && !clken) raw = 1;
    if (i == 5 && host == 0) st |= 8'h04;
    if (i == 6 && host == 0) st |= 8'h01;
  endtask : apply

  // ==========
  // Bus and event drivers
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
    if (a == OFF_CONTROL && int'(d[0]) != host) st = 0;
    if (a == OFF_CONTROL && int'(d[0]) != host) sofd = 0;
    if (a == OFF_CONTROL) host = d[0];
    if (a == OFF_EVENT_ENABLE) en = d & 8'h3f;
    if (a == OFF_EVENT_CLEAR) st = st & ~int'(d);
    if (a == OFF_RESUME_IRQ_MASK) msk = d[0];
    if (a == OFF_RESUME_IRQ_CLEAR && d[0]) raw = 0;
    cmp_irq();
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    logic [7:0] exp;
    exp = 8'h00;
    if (a == OFF_EVENT_STATUS) exp = 8'(st) & (host != 0 ? HOST_VALID_MASK : DEVICE_VALID_MASK);
    if (a == OFF_EVENT_ENABLE) exp = 8'(en);
    if (a == OFF_CONTROL) exp = 8'(host);
    if (a == OFF_RESUME_RAW_STATUS) exp = 8'(raw);
    if (a == OFF_RESUME_IRQ_MASK) exp = 8'(msk);
    @(posedge clk_in);
    req <= 1'b0;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    if (a == OFF_EVENT_STATUS) st = 0;
    cmp_data(exp);
  endtask : rd_reg

  task automatic ev_do(input int i, input logic s, input logic c);
    @(posedge clk_in);
    req <= 1'b1;
    sel <= i[2:0];
    susp <= s;
    clken <= c;
    @(posedge clk_in);
    req <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    apply(i);
    cmp_irq();
  endtask : ev_do

  // Event lands on the same edge as the clearing read
  task automatic collide(input int i);
    @(posedge clk_in);
    req <= 1'b1;
    sel <= i[2:0];
    rd_reg(OFF_EVENT_STATUS);
    apply(i);
    cmp_irq();
  endtask : collide

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ==========
  // Tests
  initial
  begin
    seed = $urandom(32'h09e5);
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_reg(OFF_EVENT_STATUS);
    rd_reg(OFF_EVENT_ENABLE);
    for (int i = 0; i < 7; i++) ev_do(i, 1'b1, 1'b1);
    wr_reg(OFF_EVENT_STATUS, 8'hff);
    rd_reg(OFF_EVENT_STATUS);
    rd_reg(OFF_EVENT_STATUS);
    $display("test device role done");
    wr_reg(OFF_CONTROL, 8'h01);
    rd_reg(OFF_CONTROL);
    ev_do(3, 1'b0, 1'b1);
    for (int i = 0; i < 7; i++) ev_do(i, 1'b1, 1'b1);
    rd_reg(OFF_EVENT_STATUS);
    $display("test host role done");
    wr_reg(OFF_EVENT_ENABLE, 8'hff);
    ev_do(2, 1'b0, 1'b1);
    collide(2);
    collide(0);
    rd_reg(OFF_EVENT_STATUS);
    ev_do(1, 1'b0, 1'b1);
    wr_reg(OFF_EVENT_CLEAR, 8'h20);
    rd_reg(8'h33);
    $display("test collide and clear done");
    ev_do(4, 1'b0, 1'b1);
    ev_do(4, 1'b1, 1'b0);
    rd_reg(OFF_RESUME_RAW_STATUS);
    wr_reg(OFF_RESUME_IRQ_MASK, 8'h01);
    rd_reg(OFF_RESUME_IRQ_MASK);
    wr_reg(OFF_RESUME_IRQ_CLEAR, 8'h01);
    rd_reg(OFF_EVENT_STATUS);
    $display("test gated resume done");
    repeat (80)
    begin
      k = $urandom % 5;
      if (k == 0) wr_reg(OFF_EVENT_ENABLE, 8'($urandom));
      if (k == 1) rd_reg(OFF_EVENT_STATUS);
      if (k == 2) wr_reg(OFF_CONTROL, 8'($urandom % 2));
      if (k > 2) ev_do($urandom % 7, 1'($urandom), 1'($urandom % 4 != 0));
    end
    $display("test random done");
    wrap_up();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    #20000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
